// ### core/mbs_pkg.sv
// Constants and types shared by the memory bus sequencer files.
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (RQ1) 16-bit read word stays stable during priority-in; taken when column strobe negates.
// (RQ2) Dynamic line usage depends on memory size: 4K, 16K or 64K parts.
// (RQ3) Multiplexed lines carry the row address first, then the column address.
// (RQ4) Address bits map to multiplexed lines out of order, per row/column table.
// (RQ5) Row strobe assertion latches row and static address; column strobe latches column.
// (RQ6) In 16-bit mode both byte read/write controls stay high throughout a read transaction.
// (RQ7) In 4K/16K dynamic mode line 0 flags an opcode read during the row.
// (RQ8) Line 0 is released before priority-in asserts.
// (RQ9) Static and 64K modes flag opcode reads with select 0 high, select 1 low.
// (RQ10) Refresh drives the refresh counter onto the multiplexed lines.
// (RQ11) Every write pairs with a preceding read, except interrupt stack writes.
// (RQ12) Dynamic mode drives the static address on the data lines concurrently.
// (RQ13) 16-bit writes drive data on all sixteen data lines for memory capture.
// (RQ14) Write byte controls: word 00, even low byte 10, odd high byte 01.
// (RQ15) Write controls assert before column strobe normally, at or after when delayed.
// (RQ16) 8-bit word access is low byte then address plus one; byte once.
// (RQ17) 8-bit mode puts high address byte on static lines, low on data lines.
// (RQ18) 8-bit read data on low data lines, taken when column strobe negates.
// (RQ19) 8-bit read strobe uses the high-byte control, normal or delayed timing.
// (RQ20) Width, static/dynamic, memory size and control timing are stable settings.
package mbs_pkg;
	// Register byte offsets on the APB side.
	localparam logic [7:0] CFG_OFF = 8'h00;
	localparam logic [7:0] ADDR_OFF = 8'h04;
	localparam logic [7:0] WDATA_OFF = 8'h08;
	localparam logic [7:0] CMD_OFF = 8'h0c;
	localparam logic [7:0] STAT_OFF = 8'h10;
	localparam logic [7:0] RDATA_OFF = 8'h14;
	// Configuration field positions and value after reset.
	localparam int CFG_WIDTH8_BIT = 0;
	localparam int CFG_DYNAMIC_BIT = 1;
	localparam int CFG_BIG64K_BIT = 2;
	localparam int CFG_DELAYED_BIT = 3;
	localparam logic [3:0] CFG_RESET = 4'h2;
	// Command field positions.
	localparam int CMD_BYTE_BIT = 2;
	localparam int CMD_FETCH_BIT = 3;
	// Status field positions.
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_REFUSED_BIT = 2;
	// Command kinds.
	localparam logic [1:0] KIND_READ = 2'h0;
	localparam logic [1:0] KIND_READ_WRITE = 2'h1;
	localparam logic [1:0] KIND_STACK_WRITE = 2'h2;
	localparam logic [1:0] KIND_REFRESH = 2'h3;
	// Select code for an opcode read, and clock cycles per bus phase.
	localparam logic [1:0] SEL_FETCH = 2'h1;
	localparam int PHASE_CYCLES = 4;
	// Bus phases of one transaction.
	typedef enum logic [2:0] {
		S_IDLE, S_ADDR, S_ROW, S_COL, S_CAS, S_PI, S_CLOSE, S_END
	} mbs_state_e;
endpackage : mbs_pkg

// ### core/mbs_sync.sv
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module mbs_sync #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// The first stage is read only by the second.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : mbs_sync

// ### core/mbs_ai_map.sv
// Row and column mapping of address bits onto the multiplexed lines.
`timescale 1ns/1ps
module mbs_ai_map (
	input wire logic [15:0] addr,
	input wire logic fetch_flag,
	input wire logic big64k,
	input wire logic column,
	output logic [7:0] lines
);
	// Lines 1 to 6 carry odd bits in the row and even bits in the column.
	always_comb
	begin
		lines = 8'h00;
		for (int k = 1; k < 7; k++)
		begin
			lines[k] = column ? addr[2*k] : addr[2*k-1]; // RQ4
		end
		if (column)
		begin
			lines[0] = addr[14]; // RQ4
			lines[7] = big64k ? addr[12] : addr[14]; // RQ2
		end
		else
		begin
			lines[0] = big64k ? addr[15] : fetch_flag; // RQ7
			lines[7] = addr[13]; // RQ2
		end
	end
endmodule : mbs_ai_map

// ### core/mbs_bus_sequencer.sv
// External memory bus sequencer with an APB register port.
`timescale 1ns/1ps
module mbs_bus_sequencer #(
	parameter int PHASE_CYCLES = mbs_pkg::PHASE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] muxed_data_address_lines_in,
	output logic [15:0] muxed_data_address_lines_out,
	output logic [15:0] muxed_data_address_lines_oe,
	output logic [7:0] row_column_address_lines_out,
	output logic [7:0] row_column_address_lines_oe,
	output logic [7:0] static_high_address_lines,
	output logic row_strobe_n,
	output logic column_strobe_n,
	output logic priority_in_strobe,
	output logic high_byte_read_write_n,
	output logic low_byte_read_write_n,
	output logic [1:0] select_code
);
	localparam logic [7:0] PC_LAST = 8'(PHASE_CYCLES - 1);

	logic width8, dynamic, big64k, delayed;
	logic [15:0] addr_reg, wdata_reg, rdata_reg;
	logic [1:0] kind;
	logic byte_op, fetch, done_flag, refused_flag;
	logic [7:0] refresh_count, phase_count, map_lines;
	logic cur_write, cur_high, read_seen, tick, start, is_ref, two_part, more;
	logic wr_en, addr_ok;
	logic [15:0] eff_addr, dal_sync;
	logic [7:0] wbyte;
	mbs_pkg::mbs_state_e state, next_state;
	logic ras_c, cas_c, pi_c, hb_c, lb_c, ctrl_on, ai_col;
	logic [15:0] dal_c, dal_oe_c;
	logic [7:0] ai_c, ai_oe_c, sal_c;
	logic [1:0] sel_c;

	////////////////////////////////////////////////////////////////////////////
	// Register port.

	// Zero wait states; unmapped addresses answer with an error.
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign addr_ok = (paddr == mbs_pkg::CFG_OFF) || (paddr == mbs_pkg::ADDR_OFF) ||
		(paddr == mbs_pkg::WDATA_OFF) || (paddr == mbs_pkg::CMD_OFF) ||
		(paddr == mbs_pkg::STAT_OFF) || (paddr == mbs_pkg::RDATA_OFF);
	assign pslverr = psel && penable && !addr_ok;
	assign start = wr_en && (paddr == mbs_pkg::CMD_OFF) && (state == mbs_pkg::S_IDLE);

	// Configuration only changes while the bus is idle, so it is stable per access.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			{delayed, big64k, dynamic, width8} <= mbs_pkg::CFG_RESET;
		else if (wr_en && paddr == mbs_pkg::CFG_OFF && state == mbs_pkg::S_IDLE)
			{delayed, big64k, dynamic, width8} <= pwdata[3:0]; // RQ20
	end

	// Address, write data and command are held for the whole sequence.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_reg <= 16'h0000;
			wdata_reg <= 16'h0000;
			kind <= mbs_pkg::KIND_READ;
			byte_op <= 1'b0;
			fetch <= 1'b0;
		end
		else if (state == mbs_pkg::S_IDLE && wr_en)
		begin
			if (paddr == mbs_pkg::ADDR_OFF)
				addr_reg <= pwdata[15:0];
			if (paddr == mbs_pkg::WDATA_OFF)
				wdata_reg <= pwdata[15:0];
			if (paddr == mbs_pkg::CMD_OFF)
			begin
				kind <= pwdata[1:0];
				byte_op <= pwdata[mbs_pkg::CMD_BYTE_BIT];
				fetch <= pwdata[mbs_pkg::CMD_FETCH_BIT];
			end
		end
	end

	// Sticky status flags; a new event wins over a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_flag <= 1'b0;
			refused_flag <= 1'b0;
		end
		else
		begin
			if (state == mbs_pkg::S_END && tick && !more)
				done_flag <= 1'b1;
			else if (wr_en && paddr == mbs_pkg::STAT_OFF && pwdata[mbs_pkg::STAT_DONE_BIT])
				done_flag <= 1'b0;
			if (wr_en && paddr == mbs_pkg::CMD_OFF && state != mbs_pkg::S_IDLE)
				refused_flag <= 1'b1;
			else if (wr_en && paddr == mbs_pkg::STAT_OFF && pwdata[mbs_pkg::STAT_REFUSED_BIT])
				refused_flag <= 1'b0;
		end
	end

	// Read data is latched in the setup cycle and stands through the access.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
		begin
			case (paddr)
				mbs_pkg::CFG_OFF: prdata <= {28'h000_0000, delayed, big64k, dynamic, width8};
				mbs_pkg::ADDR_OFF: prdata <= {16'h0000, addr_reg};
				mbs_pkg::WDATA_OFF: prdata <= {16'h0000, wdata_reg};
				mbs_pkg::CMD_OFF: prdata <= {28'h000_0000, fetch, byte_op, kind};
				mbs_pkg::STAT_OFF: prdata <= {29'h0000_0000, refused_flag, done_flag,
					state != mbs_pkg::S_IDLE};
				mbs_pkg::RDATA_OFF: prdata <= {16'h0000, rdata_reg};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Phase timing and sequencing.

	// Phase divider: one tick per bus phase while a transaction runs.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_count <= 8'h00;
		else if (state == mbs_pkg::S_IDLE || tick)
			phase_count <= 8'h00;
		else
			phase_count <= phase_count + 8'h01;
	end
	assign tick = (state != mbs_pkg::S_IDLE) && (phase_count == PC_LAST);

	assign is_ref = (kind == mbs_pkg::KIND_REFRESH);
	assign two_part = width8 && !byte_op && !is_ref;
	assign more = (two_part && !cur_high) ||
		(kind == mbs_pkg::KIND_READ_WRITE && !cur_write);
	assign eff_addr = addr_reg + {15'h0000, cur_high};
	assign wbyte = cur_high ? wdata_reg[15:8] : wdata_reg[7:0];

	// Phase order: address, row, column, column strobe, priority-in, close, end; a refresh goes from row straight to end.
	always_comb
	begin
		next_state = state;
		unique case (state)
			mbs_pkg::S_IDLE: if (start) next_state = mbs_pkg::S_ADDR;
			mbs_pkg::S_ADDR: if (tick) next_state = mbs_pkg::S_ROW;
			mbs_pkg::S_ROW: if (tick) next_state = is_ref ? mbs_pkg::S_END : mbs_pkg::S_COL;
			mbs_pkg::S_COL: if (tick) next_state = mbs_pkg::S_CAS;
			mbs_pkg::S_CAS: if (tick) next_state = mbs_pkg::S_PI;
			mbs_pkg::S_PI: if (tick) next_state = mbs_pkg::S_CLOSE;
			mbs_pkg::S_CLOSE: if (tick) next_state = mbs_pkg::S_END;
			mbs_pkg::S_END: if (tick) next_state = more ? mbs_pkg::S_ADDR : mbs_pkg::S_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= mbs_pkg::S_IDLE;
		else
			state <= next_state;
	end

	// Step order: reads before the paired write, low byte before high byte.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur_write <= 1'b0;
			cur_high <= 1'b0;
			read_seen <= 1'b0;
		end
		else if (start)
		begin
			cur_write <= (pwdata[1:0] == mbs_pkg::KIND_STACK_WRITE); // RQ11
			cur_high <= 1'b0;
			read_seen <= 1'b0;
		end
		else if (tick)
		begin
			if (state == mbs_pkg::S_PI && !cur_write)
				read_seen <= 1'b1;
			if (state == mbs_pkg::S_END && more)
			begin
				if (two_part && !cur_high)
					cur_high <= 1'b1; // RQ16
				else
				begin
					cur_write <= 1'b1; // RQ11
					cur_high <= 1'b0;
				end
			end
		end
	end

	// Read data is taken as the column strobe negates at the end of priority-in.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_reg <= 16'h0000;
		else if (tick && state == mbs_pkg::S_PI && !cur_write && !is_ref)
		begin
			if (!width8)
				rdata_reg <= dal_sync; // RQ1
			else if (cur_high)
				rdata_reg[15:8] <= dal_sync[7:0]; // RQ18
			else
				rdata_reg <= {8'h00, dal_sync[7:0]}; // RQ18
		end
	end

	// Refresh address advances after each refresh.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refresh_count <= 8'h00;
		else if (tick && state == mbs_pkg::S_END && is_ref)
			refresh_count <= refresh_count + 8'h01;
	end

	mbs_sync #(
		.WIDTH(16)
	) u_dal_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d(muxed_data_address_lines_in),
		.q(dal_sync)
	);

	mbs_ai_map u_ai_map (
		.addr(eff_addr),
		.fetch_flag(fetch && !cur_write),
		.big64k(big64k),
		.column(ai_col),
		.lines(map_lines)
	);

	////////////////////////////////////////////////////////////////////////////
	// Pin decode.

	// Strobes, byte controls and select code from the current phase.
	always_comb
	begin
		ras_c = !(state inside {mbs_pkg::S_ROW, mbs_pkg::S_COL, mbs_pkg::S_CAS,
			mbs_pkg::S_PI, mbs_pkg::S_CLOSE}); // RQ5
		cas_c = is_ref || !(state inside {mbs_pkg::S_CAS, mbs_pkg::S_PI}); // RQ5
		pi_c = (state == mbs_pkg::S_PI);
		ctrl_on = !is_ref && (delayed ? state inside {mbs_pkg::S_CAS, mbs_pkg::S_PI} :
			state inside {mbs_pkg::S_COL, mbs_pkg::S_CAS, mbs_pkg::S_PI}); // RQ15
		hb_c = 1'b1; // RQ6
		lb_c = 1'b1; // RQ6
		if (ctrl_on && cur_write)
		begin
			if (width8)
				lb_c = 1'b0;
			else if (!byte_op)
				{hb_c, lb_c} = 2'h0; // RQ14
			else
				{hb_c, lb_c} = addr_reg[0] ? 2'h1 : 2'h2; // RQ14
		end
		else if (ctrl_on && width8)
			hb_c = 1'b0; // RQ19
		sel_c = 2'h0;
		if (fetch && !cur_write && !is_ref && (width8 || big64k || !dynamic) &&
			!(width8 && cur_high) && state inside {mbs_pkg::S_ADDR, mbs_pkg::S_ROW,
			mbs_pkg::S_COL, mbs_pkg::S_CAS, mbs_pkg::S_PI, mbs_pkg::S_CLOSE})
			sel_c = mbs_pkg::SEL_FETCH; // RQ9
	end

	// Data lines carry the address first, then write data or release for reads.
	always_comb
	begin
		dal_c = 16'h0000;
		dal_oe_c = 16'h0000;
		sal_c = 8'h00;
		if (state != mbs_pkg::S_IDLE && state != mbs_pkg::S_END && !is_ref)
		begin
			if (width8)
				sal_c = eff_addr[15:8]; // RQ17
			if (state inside {mbs_pkg::S_ADDR, mbs_pkg::S_ROW, mbs_pkg::S_COL})
			begin
				dal_c = width8 ? {8'h00, eff_addr[7:0]} : eff_addr; // RQ12 RQ17
				dal_oe_c = width8 ? 16'h00ff : 16'hffff;
			end
			else if (cur_write && state != mbs_pkg::S_CLOSE)
			begin
				dal_c = width8 ? {8'h00, wbyte} : wdata_reg; // RQ13
				dal_oe_c = width8 ? 16'h00ff : 16'hffff; // RQ13
			end
		end
	end

	// Multiplexed lines: row, then column, released just before priority-in.
	always_comb
	begin
		ai_col = (state inside {mbs_pkg::S_COL, mbs_pkg::S_CAS});
		ai_c = 8'h00;
		ai_oe_c = 8'h00;
		if (is_ref && state inside {mbs_pkg::S_ADDR, mbs_pkg::S_ROW})
		begin
			ai_c = refresh_count; // RQ10
			ai_oe_c = 8'hff;
		end
		else if (!is_ref && !width8 && dynamic && (state inside {mbs_pkg::S_ADDR,
			mbs_pkg::S_ROW, mbs_pkg::S_COL} || (state == mbs_pkg::S_CAS && !tick)))
		begin
			ai_c = map_lines; // RQ3
			ai_oe_c = 8'hff; // RQ8
		end
	end

	// All memory bus pins leave flip-flops, one clock after the phase decode.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			row_strobe_n <= 1'b1;
			column_strobe_n <= 1'b1;
			priority_in_strobe <= 1'b0;
			high_byte_read_write_n <= 1'b1;
			low_byte_read_write_n <= 1'b1;
			select_code <= 2'h0;
			muxed_data_address_lines_out <= 16'h0000;
			muxed_data_address_lines_oe <= 16'h0000;
			row_column_address_lines_out <= 8'h00;
			row_column_address_lines_oe <= 8'h00;
			static_high_address_lines <= 8'h00;
		end
		else
		begin
			row_strobe_n <= ras_c;
			column_strobe_n <= cas_c;
			priority_in_strobe <= pi_c;
			high_byte_read_write_n <= hb_c;
			low_byte_read_write_n <= lb_c;
			select_code <= sel_c;
			muxed_data_address_lines_out <= dal_c;
			muxed_data_address_lines_oe <= dal_oe_c;
			row_column_address_lines_out <= ai_c;
			row_column_address_lines_oe <= ai_oe_c;
			static_high_address_lines <= sal_c;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_read_ctrl_high: // RQ6
	assert property ((!column_strobe_n && !cur_write && !width8) |->
		(high_byte_read_write_n && low_byte_read_write_n))
	else $error("A byte control went low during a read.");

	a_row_then_col: // RQ3
	assert property ($fell(column_strobe_n) |-> (!row_strobe_n && $past(!row_strobe_n, 2)))
	else $error("Column strobe fell without the row strobe held low.");

	a_fetch_release: // RQ8
	assert property ($rose(priority_in_strobe) |->
		(!row_column_address_lines_oe[0] && !$past(row_column_address_lines_oe[0])))
	else $error("Line 0 still driven at priority-in.");

	a_fetch_code: // RQ9
	assert property ((select_code == mbs_pkg::SEL_FETCH) |-> (fetch && !cur_write))
	else $error("Opcode read code shown outside an opcode read.");

	a_refresh_addr: // RQ10
	assert property ((is_ref && !row_strobe_n) |->
		(row_column_address_lines_out == refresh_count &&
		row_column_address_lines_oe == 8'hff))
	else $error("Refresh row does not carry the refresh count.");

	a_write_paired: // RQ11
	assert property (($fell(column_strobe_n) && cur_write &&
		kind != mbs_pkg::KIND_STACK_WRITE) |-> read_seen)
	else $error("Write issued without its paired read.");

	a_ctrl_normal_early: // RQ15
	assert property (($fell(column_strobe_n) && cur_write && !delayed) |->
		$past(!low_byte_read_write_n || !high_byte_read_write_n))
	else $error("Write control not ahead of column strobe.");

	a_ctrl_delayed_late: // RQ15
	assert property (($fell(column_strobe_n) && cur_write && delayed) |->
		($past(high_byte_read_write_n && low_byte_read_write_n) ##0
		(!low_byte_read_write_n || !high_byte_read_write_n)))
	else $error("Delayed write control not aligned with column strobe.");

	a_static_addr: // RQ12
	assert property (($fell(row_strobe_n) && !width8 && !is_ref) |->
		(muxed_data_address_lines_oe == 16'hffff && muxed_data_address_lines_out == eff_addr))
	else $error("Static address missing at row strobe.");

	a_low_byte_code: // RQ14
	assert property ((!column_strobe_n && cur_write && !width8 && byte_op && !addr_reg[0]) |->
		({high_byte_read_write_n, low_byte_read_write_n} == 2'h2))
	else $error("Even byte write has the wrong byte code.");
endmodule : mbs_bus_sequencer

// ### test/mbs_mem_model.sv
// Behavioural memory that answers the sequencer's bus.
`timescale 1ns/1ps
module mbs_mem_model (
	input wire logic pclk,
	input wire logic w8,
	input wire logic [15:0] mdo,
	input wire logic [15:0] mdoe,
	input wire logic [7:0] rco,
	input wire logic [7:0] rcoe,
	input wire logic [7:0] sha,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic pis,
	input wire logic hb_n,
	input wire logic lb_n,
	input wire logic [1:0] sel,
	output logic [15:0] drv = 16'h0
);
	int ntr = 0;
	int nwr = 0;
	logic [15:0] adr = 16'h0;
	logic [15:0] wdat = 16'h0;
	logic [7:0] row = 8'h0;
	logic [7:0] col = 8'h0;
	logic [7:0] rcoe_at_pis = 8'h0;
	logic [1:0] ctl = 2'h0;
	logic [1:0] sel_row = 2'h0;
	logic wr = 1'b0;
	logic p_ras = 1'b1;
	logic p_cas = 1'b1;
	logic p_pis = 1'b0;
	////////////////////////////////////////
	// Samples strobes each clock; read data is held from the column strobe to the end of
	// priority-in, then the lines float, shown as the inverse of the last value.
	always @(posedge pclk)
	begin
		if (!ras_n && p_ras)
		begin
			ntr <= ntr + 1;
			adr <= w8 ? {sha, mdo[7:0]} : mdo;
			row <= rco;
			sel_row <= sel;
		end
		if (!cas_n && p_cas)
		begin
			col <= rco;
			if (mdoe == 16'h0)
			begin
				drv <= adr ^ 16'h5a3c;
			end
		end
		if (pis)
		begin
			wdat <= mdo;
			ctl <= {hb_n, lb_n};
			wr <= (mdoe != 16'h0);
		end
		if (pis && !p_pis)
		begin
			rcoe_at_pis <= rcoe;
		end
		if (!pis && p_pis)
		begin
			nwr <= wr ? nwr + 1 : nwr;
			drv <= ~drv;
		end
		p_ras <= ras_n;
		p_cas <= cas_n;
		p_pis <= pis;
	end
endmodule : mbs_mem_model

// ### test/mbs_bus_sequencer_tb.sv
// Self-checking bench for the memory bus sequencer.
`timescale 1ns/1ps
module mbs_bus_sequencer_tb;
	typedef struct packed
	{
		logic [3:0] cfg;
		logic [15:0] addr;
		logic [3:0] cmd;
	} mbs_row_s;
	// Rows of configuration, address and command; expectations are derived per row.
	localparam mbs_row_s ROWS [12] = '{'{4'h2, 16'h1234, 4'h8}, '{4'h2, 16'h0000, 4'h3},
		'{4'h6, 16'hb67a, 4'h8}, '{4'h2, 16'h8ace, 4'h1}, '{4'h2, 16'h4ce0, 4'h5},
		'{4'h2, 16'h4ce1, 4'h5}, '{4'ha, 16'h7f10, 4'h2}, '{4'he, 16'h9001, 4'h5},
		'{4'h1, 16'h20fe, 4'h0}, '{4'h1, 16'h55a1, 4'hc}, '{4'h9, 16'h3c40, 4'h1},
		'{4'h1, 16'h6002, 4'h6}};
	localparam logic [15:0] WD = 16'hc3a5;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] md_in;
	logic [15:0] mdo;
	logic [15:0] mdoe;
	logic [7:0] rco;
	logic [7:0] rcoe;
	logic [7:0] sha;
	logic ras_n;
	logic cas_n;
	logic pis;
	logic hb_n;
	logic lb_n;
	logic [1:0] sel;
	logic [15:0] drv;
	logic w8 = 1'b0;
	logic [31:0] rd;
	logic err;
	int fail_count = 0;
	int checks = 0;
	// The wire level follows the design where it drives, else the memory.
	assign md_in = (mdoe & mdo) | (~mdoe & drv);
	mbs_bus_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .muxed_data_address_lines_in(md_in),
		.muxed_data_address_lines_out(mdo), .muxed_data_address_lines_oe(mdoe),
		.row_column_address_lines_out(rco), .row_column_address_lines_oe(rcoe),
		.static_high_address_lines(sha), .row_strobe_n(ras_n), .column_strobe_n(cas_n),
		.priority_in_strobe(pis), .high_byte_read_write_n(hb_n),
		.low_byte_read_write_n(lb_n), .select_code(sel));
	mbs_mem_model mem (.pclk, .w8, .mdo, .mdoe, .rco, .rcoe, .sha, .ras_n, .cas_n, .pis,
		.hb_n, .lb_n, .sel, .drv);
	////////////////////////////////////////
	// Clock at 200 MHz.
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	// One APB transfer; read data and error are taken at the edge where pready is high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		chk("pready", 32'h1, {31'h0, pready});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic reset_dut();
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("idle pins", 32'h1b000000, {3'h0, ras_n, cas_n, pis, hb_n, lb_n, mdoe, rcoe});
		presetn <= 1'b1;
		apb(1'b0, mbs_pkg::CFG_OFF, 32'h0);
		chk("config", {28'h0, mbs_pkg::CFG_RESET}, rd);
		apb(1'b0, mbs_pkg::STAT_OFF, 32'h0);
		chk("status", 32'h0, rd);
	endtask : reset_dut
	task automatic start(input mbs_row_s r);
		w8 = r.cfg[0];
		apb(1'b1, mbs_pkg::CFG_OFF, {28'h0, r.cfg});
		apb(1'b1, mbs_pkg::ADDR_OFF, {16'h0, r.addr});
		apb(1'b1, mbs_pkg::WDATA_OFF, {16'h0, WD});
		apb(1'b1, mbs_pkg::CMD_OFF, {28'h0, r.cmd});
	endtask : start
	task automatic wait_done();
		int n;
		n = 0;
		do
		begin
			apb(1'b0, mbs_pkg::STAT_OFF, 32'h0);
			n++;
		end
		while (rd[mbs_pkg::STAT_DONE_BIT] !== 1'b1 && n < 100);
		chk("done", 32'h1, {31'h0, rd[mbs_pkg::STAT_DONE_BIT]});
		apb(1'b1, mbs_pkg::STAT_OFF, 32'h6);
		apb(1'b0, mbs_pkg::RDATA_OFF, 32'h0);
	endtask : wait_done
	task automatic final_report();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////
	// Table loop, then refusal while busy, an unmapped access and a reset in mid-run.
	initial
	begin
		mbs_row_s r;
		logic [1:0] k;
		logic [1:0] ce;
		logic [15:0] a;
		logic [15:0] x;
		logic [15:0] y;
		int s;
		int t0;
		int w0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		reset_dut();
		foreach (ROWS[i])
		begin
			r = ROWS[i];
			k = r.cmd[1:0];
			s = (r.cfg[0] && !r.cmd[2]) ? 2 : 1;
			t0 = mem.ntr;
			w0 = mem.nwr;
			start(r);
			wait_done();
			chk("transactions", k == 1 ? 2 * s : (k == 3 ? 1 : s), mem.ntr - t0);
			chk("writes", (k == 1 || k == 2) ? s : 0, mem.nwr - w0);
			a = r.addr + 16'(s - 1);
			x = r.addr ^ 16'h5a3c;
			y = (r.addr + 16'h1) ^ 16'h5a3c;
			if (k == 0)
				ce = r.cfg[0] ? 2'b01 : 2'b11;
			else if (r.cfg[0])
				ce = 2'b10;
			else
				ce = !r.cmd[2] ? 2'b00 : (r.addr[0] ? 2'b01 : 2'b10);
			if (k == 3)
				chk("refresh lines", 32'h0, {24'h0, mem.row});
			else
			begin
				chk("address", {16'h0, a}, {16'h0, mem.adr});
				chk("controls", {30'h0, ce}, {30'h0, mem.ctl});
				chk("select", (k == 0 && r.cmd[3] && (r.cfg[0] || r.cfg[2] || !r.cfg[1])) ? 32'h1 : 32'h0,
					{30'h0, mem.sel_row});
				chk("line release", 32'h0, {24'h0, mem.rcoe_at_pis});
			end
			if (k < 2 && !r.cfg[0])
				chk("read data", {16'h0, x}, rd);
			if (k < 2 && r.cfg[0])
				chk("read data", {16'h0, s == 2 ? y[7:0] : 8'h0, x[7:0]},
					s == 2 ? rd : {24'h0, rd[7:0]});
			if ((k == 1 || k == 2) && !r.cfg[0])
				chk("write data", {16'h0, WD}, {16'h0, mem.wdat});
			if ((k == 1 || k == 2) && r.cfg[0])
				chk("write data", {24'h0, s == 2 ? WD[15:8] : WD[7:0]}, {24'h0, mem.wdat[7:0]});
			if (r.cfg[1] && !r.cfg[0] && k != 3)
			begin
				chk("row lines", {24'h0, a[13], a[11], a[9], a[7], a[5], a[3], a[1],
					r.cfg[2] ? a[15] : (k == 0 && r.cmd[3])}, {24'h0, mem.row});
				chk("column lines", {24'h0, r.cfg[2] ? a[12] : a[14], a[12], a[10], a[8], a[6],
					a[4], a[2], a[14]}, {24'h0, mem.col});
			end
		end
		t0 = mem.ntr;
		start('{4'h2, 16'h0246, 4'h0});
		apb(1'b1, mbs_pkg::ADDR_OFF, 32'hffff);
		apb(1'b1, mbs_pkg::CMD_OFF, 32'h0);
		apb(1'b0, mbs_pkg::STAT_OFF, 32'h0);
		chk("busy refused", 32'h5, rd & 32'h5);
		wait_done();
		chk("transactions", 32'h1, mem.ntr - t0);
		chk("address", 32'h0246, {16'h0, mem.adr});
		apb(1'b0, mbs_pkg::STAT_OFF, 32'h0);
		chk("status clear", 32'h0, rd);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		start('{4'h2, 16'h0000, 4'h3});
		wait_done();
		chk("refresh lines", 32'h1, {24'h0, mem.row});
		start('{4'h6, 16'h1357, 4'h1});
		repeat (10) @(posedge pclk);
		reset_dut();
		final_report();
	end
	// Cuts a hang short.
	initial
	begin
		#100000;
		fail_count++;
		final_report();
	end
endmodule : mbs_bus_sequencer_tb
